// ===== design/sbc_regs.vh
`ifndef SBC_REGS_VH
`define SBC_REGS_VH
// -----------------------------------------------------------------------
// Command byte field positions
// -----------------------------------------------------------------------
`define SBC_CMD_SLEW_HI      7
`define SBC_CMD_SLEW_LO      6
`define SBC_CMD_PULLUP_DIS   5
`define SBC_CMD_SW_C         4
`define SBC_CMD_SW_B         3
`define SBC_CMD_SW_A         2
`define SBC_CMD_OP_HI        1
`define SBC_CMD_OP_LO        0
// -----------------------------------------------------------------------
// Status byte field positions
// -----------------------------------------------------------------------
`define SBC_STS_IRQ_SRC      7
`define SBC_STS_BUS          6
`define SBC_STS_OVER         5
`define SBC_STS_UNDER        4
`define SBC_STS_REG_HOT      3
`define SBC_STS_SW_HOT       2
`define SBC_STS_WAKE_B       1
`define SBC_STS_WAKE_A       0
// -----------------------------------------------------------------------
// Encodings and reset values
// -----------------------------------------------------------------------
`define SBC_OP_SLEEP         2'h0
`define SBC_OP_STOP          2'h1
`define SBC_OP_NORMAL_WDC    2'h2
`define SBC_OP_NORMAL        2'h3
`define SBC_SLEW_NORMAL      2'h0
`define SBC_SLEW_SLOW        2'h1
`define SBC_SLEW_FAST        2'h2
`define SBC_SLEW_LOWPWR      2'h3
`define SBC_CMD_GUARD_MASK   8'hDF
`define SBC_CMD_SLEEP_BYTE   8'hC0
`define SBC_CMD_STOP_BYTE    8'hC1
`define SBC_CTRL_RESET       8'h03
`define SBC_BIT_COUNT        3'h7
`endif

// ===== design/sbc_ctrl_status.v
// Summary of operation
// - Pullup bit 0 connects pullup in low power.
// - Reset clears all three switch enables.
// - Switch C by enable; A,B also need gate.
// - Mode bits: sleep, stop, normal+clear, normal.
// - After 10 written, low mode bit returns 1.
// - Watchdog clear accepted anytime in request mode.
// - No sleep or stop on one byte.
// - Sleep byte sent twice enters sleep.
// - Stop byte sent twice enters stop.
// - Top read bit flags source versus live flags.
// - Bus bit shows bus wake or fault.
// - Overvoltage flag follows supply over comparator.
// - Undervoltage flag follows supply under comparator.
// - Regulator thermal warning reported live.
// - Switch thermal flag, hot switch turned off.
// - Low bits live wake inputs or source.
// - One byte per transfer, MSB first.
// - Status captured at chip select fall.
// - Slew bits select normal, slow, fast; low power code keeps last slew.
// - First read after reset shows battery fail.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.vh"

module sbc_ctrl_status (
  // Clock and reset
  input  wire       sys_clk_in,
  input  wire       rst_b_in,
  // Serial link from host, all asynchronous
  input  wire       spi_sclk_in,
  input  wire       spi_cs_b_in,
  input  wire       spi_mosi_in,
  output reg        spi_miso_out,
  output reg        spi_miso_oe_out,
  // Status sources, asynchronous levels
  input  wire       pwm_gate_in,
  input  wire       wake_input_a_in,
  input  wire       wake_input_b_in,
  input  wire       bus_wake_in,
  input  wire       bus_fault_in,
  input  wire       supply_over_in,
  input  wire       supply_under_in,
  input  wire       battery_fail_in,
  input  wire       regulator_thermal_warn_in,
  input  wire [2:0] switch_hot_in,
  input  wire       wake_event_in,
  // Control outputs
  output reg        load_switch_a_out,
  output reg        load_switch_b_out,
  output reg        load_switch_c_out,
  output reg        bus_pullup_on_out,
  output reg  [1:0] slew_mode_out,
  output reg        sleep_mode_out,
  output reg        stop_mode_out,
  output reg        watchdog_clear_out,
  output reg  [7:0] command_control_byte_out
);

  // -----------------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------------
  // Bit order: link pins at the bottom, status levels above, heat on top.
  localparam NSYNC = 16;
  reg [NSYNC-1:0] sync1_q;
  reg [NSYNC-1:0] sync2_q;
  wire [NSYNC-1:0] raw_w = {switch_hot_in, wake_event_in, battery_fail_in,
    regulator_thermal_warn_in, supply_under_in, supply_over_in,
    bus_fault_in, bus_wake_in, wake_input_b_in, wake_input_a_in,
    pwm_gate_in, spi_mosi_in, spi_cs_b_in, spi_sclk_in};

  // Two stages for every outside level; only stage two is read.
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // Idle link levels with select high, so release shows no select edge.
      sync1_q <= 16'h0006;
      sync2_q <= 16'h0006;
    end else begin
      sync1_q <= raw_w;
      sync2_q <= sync1_q;
    end
  end

  // Named taps on stage two; nothing reads stage one directly.
  wire       sclk_s   = sync2_q[0];
  wire       cs_b_s   = sync2_q[1];
  wire       mosi_s   = sync2_q[2];
  wire       gate_s   = sync2_q[3];
  wire [1:0] wake_s   = sync2_q[5:4];
  wire       bwake_s  = sync2_q[6];
  wire       bfault_s = sync2_q[7];
  wire       over_s   = sync2_q[8];
  wire       under_s  = sync2_q[9];
  wire       rhot_s   = sync2_q[10];
  wire       bfail_s  = sync2_q[11];
  wire       wev_s    = sync2_q[12];
  wire [2:0] shot_s   = sync2_q[15:13];

  // -----------------------------------------------------------------------
  // Edge detection on the link
  // -----------------------------------------------------------------------
  // Last seen link levels, reset to the idle pins to avoid a false edge.
  reg sclk_q;
  reg cs_b_q;

  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_q <= 1'b0;
      cs_b_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      cs_b_q <= cs_b_s;
    end
  end

  // Clock edges count only while selected, so idle wiggles are ignored.
  wire cs_fall_w   = cs_b_q & ~cs_b_s;
  wire cs_rise_w   = ~cs_b_q & cs_b_s;
  wire sclk_rise_w = ~sclk_q & sclk_s & ~cs_b_s;
  wire sclk_fall_w = sclk_q & ~sclk_s & ~cs_b_s;

  // -----------------------------------------------------------------------
  // Wake source and first-read latches
  // -----------------------------------------------------------------------
  // Wake source latch and the first-read marker for battery fail.
  reg [1:0] wake_src_q;
  reg       src_pend_q;
  reg       first_read_q;
  reg       src_shown_q;
  reg       wev_q;
  reg       src_fresh_q;
  wire      wake_edge_w = wev_s & ~wev_q;

  // Set wins over clear: a new wake in the clearing cycle stays latched.
  // A wake that lands after the snapshot was never shown, so it is kept.
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wake_src_q   <= 2'h0;
      src_pend_q   <= 1'b0;
      first_read_q <= 1'b1;
      wev_q        <= 1'b0;
      src_fresh_q  <= 1'b0;
    end else begin
      wev_q <= wev_s;
      if (wake_edge_w) begin
        src_pend_q <= 1'b1;
        wake_src_q <= wake_s;
      end else if (cs_rise_w & src_shown_q & ~src_fresh_q) begin
        src_pend_q <= 1'b0;
      end
      if (wake_edge_w)
        src_fresh_q <= 1'b1;
      else if (cs_fall_w)
        src_fresh_q <= 1'b0;
      if (cs_rise_w)
        first_read_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Status snapshot and shifter
  // -----------------------------------------------------------------------
  reg [7:0] tx_q;
  reg [7:0] rx_q;
  reg [2:0] cnt_q;
  reg       byte_ok_q;
  reg       extra_q;

  // Flags come through the synchronisers, so a snapshot is two clocks old.
  wire [7:0] status_w = {src_pend_q,
                         bwake_s | bfault_s,
                         over_s,
                         first_read_q ? bfail_s : under_s,
                         rhot_s,
                         |shot_s,
                         src_pend_q ? wake_src_q : wake_s};

  // Snapshot at select fall, shift out on falling, sample on rising.
  // Only a byte with exactly eight edges counts as a command.
  // A ninth edge marks the frame long, so sixteen edges do not pass.
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_q        <= 8'h00;
      rx_q        <= 8'h00;
      cnt_q       <= 3'h0;
      byte_ok_q   <= 1'b0;
      extra_q     <= 1'b0;
      src_shown_q <= 1'b0;
    end else if (cs_fall_w) begin
      tx_q        <= status_w;
      src_shown_q <= src_pend_q;
      cnt_q       <= 3'h0;
      byte_ok_q   <= 1'b0;
      extra_q     <= 1'b0;
    end else begin
      if (sclk_rise_w) begin
        rx_q  <= {rx_q[6:0], mosi_s};
        cnt_q <= cnt_q + 3'h1;
        extra_q   <= extra_q | byte_ok_q;
        byte_ok_q <= (cnt_q == `SBC_BIT_COUNT) & ~extra_q;
      end
      if (sclk_fall_w)
        tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // MISO drives only while selected so several devices may share it.
  // Its level is registered, one clock behind the shift register.
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      spi_miso_out    <= 1'b0;
      spi_miso_oe_out <= 1'b0;
    end else begin
      spi_miso_out    <= tx_q[7];
      spi_miso_oe_out <= ~cs_b_s;
    end
  end

  // -----------------------------------------------------------------------
  // Command decode
  // -----------------------------------------------------------------------
  // Guard bytes compare with the pullup bit masked, as it is don't-care.
  function [7:0] guard_key;
    input [7:0] b;
    begin
      guard_key = b & `SBC_CMD_GUARD_MASK;
    end
  endfunction

  function is_guard;
    input [7:0] b;
    begin
      is_guard = (guard_key(b) == `SBC_CMD_SLEEP_BYTE) |
                 (guard_key(b) == `SBC_CMD_STOP_BYTE);
    end
  endfunction

  // A command counts only when the frame held exactly eight bits.
  wire       cmd_done_w = cs_rise_w & byte_ok_q;
  reg  [7:0] ctrl_q;
  // Arming state: a first guard byte waits here for its twin.
  reg  [7:0] pend_q;
  reg        pend_v_q;
  reg        wdc_q;
  reg        sleep_q;
  reg        stop_q;

  // The host is trusted to send both mode bits in one byte.
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q   <= `SBC_CTRL_RESET;
      pend_q   <= 8'h00;
      pend_v_q <= 1'b0;
      wdc_q    <= 1'b0;
      sleep_q  <= 1'b0;
      stop_q   <= 1'b0;
    end else begin
      wdc_q <= 1'b0;
      if (cmd_done_w) begin
        if (is_guard(rx_q)) begin
          // First guarded byte only arms; a second that matches it outside the pullup bit acts.
          if (pend_v_q && (guard_key(rx_q) == guard_key(pend_q))) begin
            ctrl_q   <= rx_q;
            sleep_q  <= (rx_q[1:0] == `SBC_OP_SLEEP);
            stop_q   <= (rx_q[1:0] == `SBC_OP_STOP);
            pend_v_q <= 1'b0;
          end else begin
            pend_q   <= rx_q;
            pend_v_q <= 1'b1;
          end
        end else begin
          // Any other byte drops an armed guard and leaves low power.
          pend_v_q <= 1'b0;
          sleep_q  <= 1'b0;
          stop_q   <= 1'b0;
          if (rx_q[1:0] == `SBC_OP_NORMAL_WDC) begin
            // Clear taken in any phase, no window here.
            wdc_q  <= 1'b1;
            ctrl_q <= {rx_q[7:1], 1'b1};
          end else if (rx_q[1]) begin
            ctrl_q <= rx_q;
          end else begin
            // A lone sleep/stop code that is not a guard byte keeps mode.
            ctrl_q <= {rx_q[7:2], ctrl_q[1:0]};
          end
        end
      end else if (wake_edge_w) begin
        // A wake event ends low power at once, but only in a cycle where no command completes.
        sleep_q <= 1'b0;
        stop_q  <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  wire low_pwr_w = sleep_q | stop_q;
  wire [2:0] sw_en_w = {ctrl_q[`SBC_CMD_SW_C], ctrl_q[`SBC_CMD_SW_B],
                        ctrl_q[`SBC_CMD_SW_A]};
  wire [2:0] sw_ok_w;

  // One permission per switch: enable set, not hot, not in low power.
  // Only switch C ignores the gate; A and B are the modulated pair.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sw
      assign sw_ok_w[gi] = sw_en_w[gi] & ~shot_s[gi] & ~low_pwr_w &
                           (gate_s | (gi == 2));
    end
  endgenerate

  // Every output is a flop, so the pins never see decode glitches.
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      load_switch_a_out        <= 1'b0;
      load_switch_b_out        <= 1'b0;
      load_switch_c_out        <= 1'b0;
      bus_pullup_on_out        <= 1'b0;
      slew_mode_out            <= `SBC_SLEW_NORMAL;
      sleep_mode_out           <= 1'b0;
      stop_mode_out            <= 1'b0;
      watchdog_clear_out       <= 1'b0;
      command_control_byte_out <= `SBC_CTRL_RESET;
    end else begin
      // A hot switch is forced off at once.
      load_switch_a_out <= sw_ok_w[0];
      load_switch_b_out <= sw_ok_w[1];
      load_switch_c_out <= sw_ok_w[2];
      bus_pullup_on_out <= low_pwr_w &
                           ~ctrl_q[`SBC_CMD_PULLUP_DIS];
      // The low-power code leaves the previous slew in force.
      if (ctrl_q[7:6] != `SBC_SLEW_LOWPWR)
        slew_mode_out <= ctrl_q[7:6];
      sleep_mode_out           <= sleep_q;
      stop_mode_out            <= stop_q;
      watchdog_clear_out       <= wdc_q;
      command_control_byte_out <= ctrl_q;
    end
  end

endmodule // sbc_ctrl_status
`default_nettype wire

// ===== verification/sbc_ctrl_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Pin checks on the status block
// ------------------------------
module sbc_ctrl_status_monitor (
  // Clock and reset
  input wire logic       sys_clk_in,
  input wire logic       rst_b_in,
  // Link and control pins
  input wire logic       spi_cs_b_in,
  input wire logic       spi_miso_oe_out,
  input wire logic       load_switch_a_out,
  input wire logic       load_switch_c_out,
  input wire logic       bus_pullup_on_out,
  input wire logic       sleep_mode_out,
  input wire logic       stop_mode_out,
  input wire logic       watchdog_clear_out,
  input wire logic [7:0] command_control_byte_out
);
  // Short alias; outputs may trail the byte copy by a cycle.
  wire logic [7:0] cb = command_control_byte_out;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  rst_ctrl_a:
    assert property ($rose(rst_b_in) |-> cb == 8'h03 && !load_switch_c_out)
    else $error("Control byte not at reset value.");
  sw_c_en_a:
    assert property (load_switch_c_out |-> cb[4] || $past(cb[4]))
    else $error("Switch c on without enable.");
  sw_a_en_a:
    assert property (load_switch_a_out |-> cb[2] || $past(cb[2]))
    else $error("Switch a on without enable.");
  wdc_pulse_a:
    assert property (watchdog_clear_out |=> !watchdog_clear_out)
    else $error("Watchdog clear longer than one cycle.");
  wdc_mode_a:
    assert property (watchdog_clear_out |-> ##[0:2] cb[1:0] == 2'b11)
    else $error("Low mode bit not restored.");
  mode_excl_a:
    assert property (!(sleep_mode_out && stop_mode_out))
    else $error("Sleep and stop together.");
  sleep_cmd_a:
    assert property ($rose(sleep_mode_out) |-> ##[0:1] (cb & 8'hDF) == 8'hC0)
    else $error("Sleep without sleep byte.");
  stop_cmd_a:
    assert property ($rose(stop_mode_out) |-> ##[0:1] (cb & 8'hDF) == 8'hC1)
    else $error("Stop without stop byte.");
  pullup_lp_a:
    assert property ($rose(sleep_mode_out || stop_mode_out)
      |-> ##[0:1] bus_pullup_on_out == !cb[5])
    else $error("Pullup wrong in low power.");
  oe_frame_a:
    assert property ($fell(spi_cs_b_in) |-> ##[1:6] spi_miso_oe_out)
    else $error("Serial output not driven in frame.");
  // Main scenarios.
  cover property ($rose(sleep_mode_out));
  cover property ($rose(stop_mode_out));
  cover property (watchdog_clear_out);
endmodule // sbc_ctrl_status_monitor

bind sbc_ctrl_status sbc_ctrl_status_monitor i_mon (.sys_clk_in, .rst_b_in,
  .spi_cs_b_in, .spi_miso_oe_out, .load_switch_a_out, .load_switch_c_out,
  .bus_pullup_on_out, .sleep_mode_out, .stop_mode_out, .watchdog_clear_out,
  .command_control_byte_out);
`default_nettype wire

// ===== verification/sbc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------
// Host master of serial link
// ---------------------------
module sbc_host_model #(parameter int GAP_NS = 60) (
  // Link pins
  output logic      spi_sclk_out,
  output logic      spi_cs_b_out,
  output logic      spi_mosi_out,
  input  wire logic spi_miso_in,
  input  wire logic spi_miso_oe_in
);
  logic last_q;
  // A released line shows the inverse of its last bit, never a kind 0.
  wire logic line = spi_miso_oe_in ? spi_miso_in : ~last_q;
  // Idle: clock low and still, chip select high.
  initial begin
    spi_sclk_out = 1'b0;
    spi_cs_b_out = 1'b1;
    spi_mosi_out = 1'b0;
    last_q = 1'b0;
  end
  // One whole byte, mode 0, top bit first both ways.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    spi_cs_b_out <= 1'b0;
    #48;
    for (int i = 7; i >= 0; i--) begin
      spi_mosi_out <= tx[i];
      #24 spi_sclk_out <= 1'b1;
      rx[i] = line;
      last_q = line;
      #24 spi_sclk_out <= 1'b0;
    end
    #24 spi_cs_b_out <= 1'b1;
    spi_mosi_out <= ~spi_mosi_out;
    #(GAP_NS);
  endtask
endmodule // sbc_host_model
`default_nettype wire

// ===== verification/sbc_ctrl_status_test.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------
// Bench for the status block
// ---------------------------
module sbc_ctrl_status_test;
  logic            clk = 1'b0;
  logic            rst_b = 1'b0;
  logic [12:0]     st = 13'h0080;
  logic            sclk, cs_b, mosi;
  wire logic       miso, oe, sa, sb, sc, pu, slp, stp, wdc;
  wire logic [1:0] slew;
  wire logic [7:0] cb;
  logic [7:0]      rx;
  int              err_count = 0;
  int              checks_done = 0;
  int              wdc_n = 0;
  // System clock, 5 ns period.
  always #2.5 clk = ~clk;
  sbc_ctrl_status i_dut (.sys_clk_in(clk), .rst_b_in(rst_b),
    .spi_sclk_in(sclk), .spi_cs_b_in(cs_b), .spi_mosi_in(mosi),
    .spi_miso_out(miso), .spi_miso_oe_out(oe), .pwm_gate_in(st[0]),
    .wake_input_a_in(st[1]), .wake_input_b_in(st[2]), .bus_wake_in(st[3]),
    .bus_fault_in(st[4]), .supply_over_in(st[5]), .supply_under_in(st[6]),
    .battery_fail_in(st[7]), .regulator_thermal_warn_in(st[8]),
    .switch_hot_in(st[11:9]), .wake_event_in(st[12]),
    .load_switch_a_out(sa), .load_switch_b_out(sb), .load_switch_c_out(sc),
    .bus_pullup_on_out(pu), .slew_mode_out(slew), .sleep_mode_out(slp),
    .stop_mode_out(stp), .watchdog_clear_out(wdc),
    .command_control_byte_out(cb));
  sbc_host_model i_host (.spi_sclk_out(sclk), .spi_cs_b_out(cs_b),
    .spi_mosi_out(mosi), .spi_miso_in(miso), .spi_miso_oe_in(oe));
  // Counts one-cycle clear pulses.
  always @(posedge clk) if (wdc) wdc_n++;
  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // Every frame writes a byte and returns the status in rx.
  task automatic wr(input logic [7:0] b);
    i_host.xfer(b, rx);
    repeat (10) @(posedge clk);
  endtask
  // Status levels change at an edge, then settle through the syncs.
  task automatic set_st(input logic [12:0] v);
    @(posedge clk);
    st <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    cmp("ctrl byte", 8'h03, cb);
    wr(8'h03);
    cmp("first read", 8'h10, rx);
    set_st(13'h0573);
    wr(8'h03);
    cmp("live read", 8'h7D, rx);
    $display("test status done");
    wr(8'h1F);
    cmp("hot b off", 8'h05, {5'h0, sc, sb, sa});
    set_st(13'h0000);
    cmp("gate low", 8'h04, {5'h0, sc, sb, sa});
    for (int s = 0; s < 4; s++) begin
      wr({s[1:0], 6'h1F});
      cmp("slew", {6'h0, (s == 3) ? 2'h2 : s[1:0]}, {6'h0, slew});
    end
    wr(8'h1E);
    cmp("wdc pulses", 8'h01, wdc_n[7:0]);
    cmp("mode bits", 8'h03, {6'h0, cb[1:0]});
    $display("test control done");
    set_st(13'h0040);
    cmp("pre reset", 8'h04, {5'h0, sc, sb, sa});
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    cmp("reset sw", 8'h00, {5'h0, sc, sb, sa});
    cmp("reset ctrl", 8'h03, cb);
    wr(8'h03);
    cmp("reset read", 8'h00, rx);
    wr(8'h03);
    cmp("under read", 8'h10, rx);
    set_st(13'h0000);
    $display("test reset done");
    wr(8'hC0);
    wr(8'h1F);
    wr(8'hC0);
    cmp("one byte", 8'h00, {7'h0, slp});
    wr(8'hC0);
    cmp("sleep", 8'h01, {7'h0, slp});
    cmp("pullup", 8'h01, {7'h0, pu});
    $display("test sleep done");
    set_st(13'h0004);
    set_st(13'h1004);
    set_st(13'h0000);
    wr(8'h03);
    cmp("wake src", 8'h82, rx);
    wr(8'h03);
    cmp("after src", 8'h00, rx);
    $display("test wake done");
    wr(8'hE1);
    wr(8'hE1);
    cmp("stop", 8'h01, {7'h0, stp});
    cmp("pullup off", 8'h00, {7'h0, pu});
    $display("test stop done");
    summarize;
  end
  // Whole run is about 11 us; this cuts a hang short.
  initial begin
    #200000;
    err_count++;
    summarize;
  end
endmodule // sbc_ctrl_status_test
`default_nettype wire
